// ==== hdl/tdm_pkg.sv ====
package tdm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TDM_OFF_CTRL     = 8'h00;
  localparam logic [7:0] TDM_OFF_DET_EN   = 8'h04;
  localparam logic [7:0] TDM_OFF_STATUS   = 8'h08;
  localparam logic [7:0] TDM_OFF_EXT_HI   = 8'h0c;
  localparam logic [7:0] TDM_OFF_EXT_LO   = 8'h10;
  localparam logic [7:0] TDM_OFF_EXP_HASH = 8'h14;
  localparam logic [7:0] TDM_OFF_HASH_KEY = 8'h18;
  localparam logic [7:0] TDM_OFF_PEN_SEL  = 8'h1c;

  localparam int TDM_NUM_REGS = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TDM_RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] TDM_RST_DET_EN  = 32'h0000_01ff;
  localparam logic [11:0] TDM_RST_EXT_HI  = 12'hfff;
  localparam logic [11:0] TDM_RST_EXT_LO  = 12'h000;
  localparam logic [31:0] TDM_RST_HASH    = 32'h0000_0000;
  localparam logic [1:0]  TDM_RST_PEN_SEL = 2'h3;

  // ----------------------------------------------------------------
  // Field layout and source indices
  // ----------------------------------------------------------------
  localparam int TDM_CTRL_GO_BIT = 7;
  localparam int TDM_EXT_W       = 12;
  localparam int TDM_NUM_ALARM   = 4;
  localparam int TDM_NUM_SRC     = 9;
  localparam int TDM_NUM_EDGE    = 5;
  localparam int TDM_HASH_ROT    = 5;
  localparam int TDM_ID_WORDS    = 4;

  localparam int TDM_SRC_TCK     = 0;
  localparam int TDM_SRC_TDI_R   = 1;
  localparam int TDM_SRC_TDI_F   = 2;
  localparam int TDM_SRC_TMS_R   = 3;
  localparam int TDM_SRC_TMS_F   = 4;
  localparam int TDM_SRC_INTEG   = 5;
  localparam int TDM_SRC_ID      = 6;
  localparam int TDM_SRC_MON     = 7;
  localparam int TDM_SRC_EXT     = 8;

  localparam logic [1:0] TDM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TDM_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] rsvd;
    logic        id_go;
    logic        scrub_en;
    logic        cfg_hold;
    logic        fuse_arm;
    logic [1:0]  chain_sel;
    logic        master_take;
    logic        chain_break;
  } tdm_ctrl_t;

  typedef struct packed {
    logic [14:0] rsvd;
    logic        vref_internal;
    logic        penalty;
    logic        id_ok;
    logic        id_done;
    logic [3:0]  spare;
    logic [TDM_NUM_SRC-1:0] sticky;
  } tdm_status_t;

  typedef struct packed {
    logic [95:0] serial;
    logic [31:0] fuse;
  } tdm_ident_t;

  typedef enum logic [3:0] {
    TDM_ID_IDLE = 4'b0001,
    TDM_ID_HASH = 4'b0010,
    TDM_ID_CMP  = 4'b0100,
    TDM_ID_DONE = 4'b1000
  } tdm_id_state_t;

endpackage

// ==== hdl/tdm_top.sv ====
`timescale 1ns/1ns
module tdm_top
  import tdm_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     scan_tck,
  input  wire logic                     scan_tdi,
  input  wire logic                     scan_tms,
  input  wire tdm_ident_t               ident,
  input  wire logic                     integrity_err,
  input  wire logic [TDM_NUM_ALARM-1:0] monitor_alarm,
  input  wire logic                     vref_internal,
  input  wire logic [TDM_EXT_W-1:0]     ext_sample,
  input  wire logic                     ext_sample_valid,
  output logic                          chain_break,
  output logic                          master_take,
  output logic [2:0]                    user_chain,
  output logic                          scan_config_refuse,
  output logic                          config_hold,
  output logic                          scrub_enable,
  output logic                          fuse_burn_req,
  output logic                          design_active,
  output logic                          limited_mode,
  output logic                          penalty_req,
  output logic                          outputs_off,
  output logic                          flops_restore
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    reg_index = addr[4:2];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr[7:5] == 3'h0);
  endfunction

  function automatic logic [31:0] hash_step(input logic [31:0] h,
                                            input logic [31:0] w,
                                            input logic [31:0] k);
    logic [31:0] x;
    x = h ^ w;
    hash_step = {x[31-TDM_HASH_ROT:0], x[31:32-TDM_HASH_ROT]} + k;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tdm_ctrl_t              ctrl;
  logic [TDM_NUM_SRC-1:0] det_en;
  logic [TDM_EXT_W-1:0]   ext_hi;
  logic [TDM_EXT_W-1:0]   ext_lo;
  logic [31:0]            exp_hash;
  logic [31:0]            hash_key;
  logic [1:0]             pen_sel;
  logic [TDM_NUM_SRC-1:0] sticky;
  logic                   id_done;
  logic                   id_ok;
  tdm_status_t            status;
  logic                   vref_s1;
  logic                   vref_s2;

  logic       aw_got;
  logic       w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       id_go;

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TDM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? TDM_RESP_OKAY : TDM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got        <= 1'b0;
        w_got         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes; status is read-only and ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= TDM_RST_CTRL;
      det_en   <= TDM_RST_DET_EN[TDM_NUM_SRC-1:0];
      ext_hi   <= TDM_RST_EXT_HI;
      ext_lo   <= TDM_RST_EXT_LO;
      exp_hash <= TDM_RST_HASH;
      hash_key <= TDM_RST_HASH;
      pen_sel  <= TDM_RST_PEN_SEL;
      id_go    <= 1'b0;
    end else begin
      id_go <= 1'b0;
      if (wr_fire && mapped(aw_addr)) begin
        case (reg_index(aw_addr))
          reg_index(TDM_OFF_CTRL): begin
            if (w_strb[0]) begin
              // Chain break and master takeover are one-way until reconfiguration
              ctrl.chain_break <= ctrl.chain_break | w_data[0];
              ctrl.master_take <= ctrl.master_take | w_data[1];
              ctrl.chain_sel   <= w_data[3:2];
              ctrl.fuse_arm    <= w_data[4];
              ctrl.cfg_hold    <= w_data[5];
              ctrl.scrub_en    <= w_data[6];
              id_go            <= w_data[TDM_CTRL_GO_BIT];
            end
          end
          reg_index(TDM_OFF_DET_EN): begin
            if (w_strb[0]) det_en[7:0] <= w_data[7:0];
            if (w_strb[1]) det_en[8] <= w_data[8];
          end
          reg_index(TDM_OFF_EXT_HI): begin
            if (w_strb[0]) ext_hi[7:0] <= w_data[7:0];
            if (w_strb[1]) ext_hi[11:8] <= w_data[11:8];
          end
          reg_index(TDM_OFF_EXT_LO): begin
            if (w_strb[0]) ext_lo[7:0] <= w_data[7:0];
            if (w_strb[1]) ext_lo[11:8] <= w_data[11:8];
          end
          reg_index(TDM_OFF_EXP_HASH): begin
            for (int b = 0; b < 4; b++) begin
              if (w_strb[b]) exp_hash[8*b +: 8] <= w_data[8*b +: 8];
            end
          end
          reg_index(TDM_OFF_HASH_KEY): begin
            for (int b = 0; b < 4; b++) begin
              if (w_strb[b]) hash_key[8*b +: 8] <= w_data[8*b +: 8];
            end
          end
          reg_index(TDM_OFF_PEN_SEL): begin
            if (w_strb[0]) pen_sel <= w_data[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    status               = '0;
    status.sticky        = sticky;
    status.id_done       = id_done;
    status.id_ok         = id_ok;
    status.penalty       = penalty_req;
    status.vref_internal = vref_s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TDM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? TDM_RESP_OKAY : TDM_RESP_SLVERR;
      case (reg_index(s_axi_araddr))
        reg_index(TDM_OFF_CTRL):     s_axi_rdata <= {25'h0, ctrl[6:0]};
        reg_index(TDM_OFF_DET_EN):   s_axi_rdata <= {23'h0, det_en};
        reg_index(TDM_OFF_STATUS):   s_axi_rdata <= status;
        reg_index(TDM_OFF_EXT_HI):   s_axi_rdata <= {20'h0, ext_hi};
        reg_index(TDM_OFF_EXT_LO):   s_axi_rdata <= {20'h0, ext_lo};
        reg_index(TDM_OFF_EXP_HASH): s_axi_rdata <= exp_hash;
        reg_index(TDM_OFF_HASH_KEY): s_axi_rdata <= hash_key;
        default:                     s_axi_rdata <= {30'h0, pen_sel};
      endcase
      if (!mapped(s_axi_araddr)) s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Scan-clock domain: edge watch on TCK, TDI, TMS
  // ----------------------------------------------------------------
  // TCK only runs during scan activity, so each event becomes a toggle
  // that the fabric clock picks up whenever it arrives.
  logic                    tck_resetn_s1;
  logic                    tck_resetn_s2;
  logic                    tdi_q;
  logic                    tms_q;
  logic [TDM_NUM_EDGE-1:0] edge_tgl;

  always_ff @(posedge scan_tck) begin
    tck_resetn_s1 <= aresetn;
    tck_resetn_s2 <= tck_resetn_s1;
  end

  always_ff @(posedge scan_tck) begin
    if (!tck_resetn_s2) begin
      // Follow the pins in reset so the first active edge sees no false edge
      tdi_q    <= scan_tdi;
      tms_q    <= scan_tms;
      edge_tgl <= '0;
    end else begin
      tdi_q <= scan_tdi;
      tms_q <= scan_tms;
      edge_tgl[TDM_SRC_TCK]   <= ~edge_tgl[TDM_SRC_TCK];
      edge_tgl[TDM_SRC_TDI_R] <= edge_tgl[TDM_SRC_TDI_R] ^ (scan_tdi & ~tdi_q);
      edge_tgl[TDM_SRC_TDI_F] <= edge_tgl[TDM_SRC_TDI_F] ^ (~scan_tdi & tdi_q);
      edge_tgl[TDM_SRC_TMS_R] <= edge_tgl[TDM_SRC_TMS_R] ^ (scan_tms & ~tms_q);
      edge_tgl[TDM_SRC_TMS_F] <= edge_tgl[TDM_SRC_TMS_F] ^ (~scan_tms & tms_q);
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the fabric clock
  // ----------------------------------------------------------------
  logic [TDM_NUM_EDGE-1:0] tgl_s1;
  logic [TDM_NUM_EDGE-1:0] tgl_s2;
  logic [TDM_NUM_EDGE-1:0] tgl_s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgl_s1  <= '0;
      tgl_s2  <= '0;
      tgl_s3  <= '0;
      vref_s1 <= 1'b0;
      vref_s2 <= 1'b0;
    end else begin
      tgl_s1  <= edge_tgl;
      tgl_s2  <= tgl_s1;
      tgl_s3  <= tgl_s2;
      vref_s1 <= vref_internal;
      vref_s2 <= vref_s1;
    end
  end

  // ----------------------------------------------------------------
  // Identifier hash check
  // ----------------------------------------------------------------
  tdm_id_state_t state;
  logic [1:0]    word_idx;
  logic [31:0]   hash_acc;
  logic [31:0]   id_word;

  always_comb begin
    case (word_idx)
      2'h0:    id_word = ident.serial[31:0];
      2'h1:    id_word = ident.serial[63:32];
      2'h2:    id_word = ident.serial[95:64];
      default: id_word = ident.fuse;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= TDM_ID_IDLE;
      word_idx <= 2'h0;
      hash_acc <= 32'h0000_0000;
      id_done  <= 1'b0;
      id_ok    <= 1'b0;
    end else begin
      case (state)
        TDM_ID_IDLE: begin
          if (id_go) begin
            state    <= TDM_ID_HASH;
            word_idx <= 2'h0;
            hash_acc <= hash_key;
          end
        end
        TDM_ID_HASH: begin
          hash_acc <= hash_step(hash_acc, id_word, hash_key);
          word_idx <= word_idx + 2'h1;
          if (word_idx == 2'(TDM_ID_WORDS - 1)) state <= TDM_ID_CMP;
        end
        TDM_ID_CMP: begin
          id_done <= 1'b1;
          id_ok   <= (hash_acc == exp_hash);
          state   <= TDM_ID_DONE;
        end
        TDM_ID_DONE: begin
          // One check per configuration; a replay cannot clear a failure
          state <= TDM_ID_DONE;
        end
        default: state <= TDM_ID_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky detectors and penalty
  // ----------------------------------------------------------------
  logic [TDM_NUM_SRC-1:0] src_hit;
  logic                   ext_out;

  assign ext_out = ext_sample_valid && ((ext_sample > ext_hi) || (ext_sample < ext_lo));

  always_comb begin
    src_hit                = '0;
    src_hit[TDM_NUM_EDGE-1:0] = tgl_s2 ^ tgl_s3;
    src_hit[TDM_SRC_INTEG] = integrity_err;
    src_hit[TDM_SRC_ID]    = (state == TDM_ID_CMP) && (hash_acc != exp_hash);
    src_hit[TDM_SRC_MON]   = |monitor_alarm;
    src_hit[TDM_SRC_EXT]   = ext_out;
  end

  // Only reconfiguration (reset) clears these; software cannot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky <= '0;
    end else begin
      sticky <= sticky | src_hit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      penalty_req        <= 1'b0;
      outputs_off        <= 1'b0;
      flops_restore      <= 1'b0;
      fuse_burn_req      <= 1'b0;
      chain_break        <= 1'b0;
      master_take        <= 1'b0;
      user_chain         <= 3'h1;
      scan_config_refuse <= 1'b0;
      config_hold        <= 1'b0;
      scrub_enable       <= 1'b0;
      design_active      <= 1'b0;
      limited_mode       <= 1'b0;
    end else begin
      penalty_req        <= penalty_req | (|(sticky & det_en));
      outputs_off        <= outputs_off | (penalty_req & pen_sel[0]);
      flops_restore      <= flops_restore | (penalty_req & pen_sel[1]);
      fuse_burn_req      <= fuse_burn_req | (penalty_req & ctrl.fuse_arm & ctrl.master_take);
      chain_break        <= ctrl.chain_break;
      master_take        <= ctrl.master_take;
      user_chain         <= {1'b0, ctrl.chain_sel} + 3'h1;
      scan_config_refuse <= ctrl.chain_break;
      config_hold        <= ctrl.cfg_hold;
      scrub_enable       <= ctrl.scrub_en;
      design_active      <= id_done & id_ok & ~penalty_req;
      limited_mode       <= id_done & ~id_ok;
    end
  end

endmodule

// ==== dv/tdm_top_asserts.sv ====
`timescale 1ns/1ns
module tdm_top_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       chain_break,
  input wire logic       master_take,
  input wire logic [2:0] user_chain,
  input wire logic       scan_config_refuse,
  input wire logic       fuse_burn_req,
  input wire logic       design_active,
  input wire logic       limited_mode,
  input wire logic       penalty_req,
  input wire logic       outputs_off,
  input wire logic       flops_restore
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_break_held: assert property (chain_break |=> chain_break)
    else $error("chain break released");
  a_chain_range: assert property (user_chain inside {[3'd1:3'd4]})
    else $error("user chain out of range");
  a_take_held: assert property ($rose(master_take) |=> master_take [*4])
    else $error("master takeover released");
  a_fuse_cause: assert property (fuse_burn_req |-> penalty_req && master_take)
    else $error("fuse burn without penalty and takeover");
  a_refuse_break: assert property (chain_break |-> scan_config_refuse)
    else $error("scan configuration open while chain broken");
  a_id_exclusive: assert property (!(design_active && limited_mode))
    else $error("active and limited at once");
  a_alarm_drop: assert property ($rose(penalty_req) |-> ##[0:2] !design_active)
    else $error("design still active after penalty");
  a_off_cause: assert property (outputs_off |-> penalty_req ##1 outputs_off)
    else $error("outputs off without penalty or released");
  a_restore_cause: assert property (flops_restore |-> penalty_req ##1 flops_restore)
    else $error("restore without penalty or released");
  a_penalty_held: assert property (penalty_req |=> penalty_req)
    else $error("penalty request dropped");
endmodule

bind tdm_top tdm_top_asserts i_tdm_top_asserts (
  .aclk, .aresetn, .chain_break, .master_take, .user_chain, .scan_config_refuse,
  .fuse_burn_req, .design_active, .limited_mode, .penalty_req, .outputs_off,
  .flops_restore
);

// ==== dv/tdm_tap_model.sv ====
`timescale 1ns/1ns
module tdm_tap_model (
  output logic tck,
  output logic tdi,
  output logic tms
);
  // ----------------------------------------------------------------
  // Host frame driver
  // ----------------------------------------------------------------
  // Clock stands low between frames; data lines rest at pull-up level
  initial begin
    tck = 1'b0;
    tdi = 1'b1;
    tms = 1'b1;
  end

  task automatic frame(input logic [7:0] di, input logic [7:0] ms);
    #5;
    for (int i = 0; i < 8; i++) begin
      tdi = di[i];
      tms = ms[i];
      #32 tck = 1'b1;
      #32 tck = 1'b0;
    end
    tdi = 1'b1;
    tms = 1'b1;
  endtask
endmodule

// ==== dv/test_tamper_detect_monitor.sv ====
`timescale 1ns/1ns
module test_tamper_detect_monitor
  import tdm_pkg::*;
;
  localparam logic [31:0] KEY = 32'h3c6e_f372;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, scan_tck, scan_tdi, scan_tms;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        integrity_err, vref_internal, ext_sample_valid, chain_break;
  logic        master_take, scan_config_refuse, config_hold, scrub_enable;
  logic        fuse_burn_req, design_active, limited_mode, penalty_req;
  logic        outputs_off, flops_restore;
  logic [2:0]  user_chain;
  logic [3:0]  monitor_alarm;
  logic [11:0] ext_sample;
  tdm_ident_t  ident;
  tdm_status_t st;
  int          fails, n_tests;

  tdm_top i_tdm_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_tck, .scan_tdi, .scan_tms, .ident, .integrity_err,
    .monitor_alarm, .vref_internal, .ext_sample, .ext_sample_valid, .chain_break,
    .master_take, .user_chain, .scan_config_refuse, .config_hold, .scrub_enable,
    .fuse_burn_req, .design_active, .limited_mode, .penalty_req, .outputs_off,
    .flops_restore
  );
  tdm_tap_model i_tdm_tap_model (.tck(scan_tck), .tdi(scan_tdi), .tms(scan_tms));

  always #4 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    st = rdv;
  endtask

  // Independent model of the keyed identifier hash
  function automatic logic [31:0] hsh(input tdm_ident_t id, input logic [31:0] k);
    logic [31:0]  h;
    logic [31:0]  x;
    logic [127:0] v;
    h = k;
    v = {id.fuse, id.serial};
    for (int i = 0; i < 4; i++) begin
      x = h ^ v[32*i +: 32];
      h = {x[26:0], x[31:27]} + k;
    end
    return h;
  endfunction

  // Scan domain resets only on its own clock, so a frame runs in reset
  task automatic rst();
    aresetn <= 1'b0;
    i_tdm_tap_model.frame(8'h00, 8'h00);
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic id_run(input logic [31:0] exp_hash);
    wr(TDM_OFF_HASH_KEY, KEY, 4'hf);
    wr(TDM_OFF_EXP_HASH, exp_hash, 4'hf);
    wr(TDM_OFF_CTRL, 32'h80, 4'hf);
    st = '0;
    for (int i = 0; i < 20 && st.id_done !== 1'b1; i++) rd(TDM_OFF_STATUS);
    repeat (4) @(posedge aclk);
    rd(TDM_OFF_STATUS);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    chk({chain_break, master_take, scan_config_refuse, penalty_req, outputs_off}, 0);
    chk(user_chain, 1);
    rd(TDM_OFF_DET_EN);
    chk(rdv, TDM_RST_DET_EN);
    rd(TDM_OFF_EXT_HI);
    chk(rdv, TDM_RST_EXT_HI);
    rd(TDM_OFF_PEN_SEL);
    chk(rdv, TDM_RST_PEN_SEL);
    rd(8'h20);
    chk({resp, rdv}, {TDM_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'hffff_ffff, 4'hf);
    chk(resp, TDM_RESP_SLVERR);
    wr(TDM_OFF_DET_EN, 32'h0000_0040, 4'h2);
    rd(TDM_OFF_DET_EN);
    chk(rdv, 32'h0ff);
  endtask

  task automatic t_chain();
    for (int v = 0; v < 4; v++) begin
      wr(TDM_OFF_CTRL, {28'h0, v[1:0], 2'b00}, 4'hf);
      repeat (2) @(posedge aclk);
      chk(user_chain, v + 1);
    end
    wr(TDM_OFF_CTRL, 32'h63, 4'hf);
    repeat (2) @(posedge aclk);
    chk({chain_break, master_take, scan_config_refuse, config_hold, scrub_enable}, 5'h1f);
    wr(TDM_OFF_CTRL, 32'h0, 4'hf);
    repeat (2) @(posedge aclk);
    chk({chain_break, master_take, config_hold, user_chain}, 6'b110001);
  endtask

  task automatic t_id_bad();
    id_run(hsh(ident, KEY) ^ 32'h1);
    chk({st.id_done, st.id_ok, st.sticky[TDM_SRC_ID], st.penalty}, 4'b1011);
    chk({design_active, limited_mode, penalty_req, outputs_off}, 4'b0111);
    chk({flops_restore, fuse_burn_req}, 2'b10);
  endtask

  task automatic t_id_good();
    wr(TDM_OFF_DET_EN, 32'h0, 4'hf);
    id_run(hsh(ident, KEY));
    chk({st.id_done, st.id_ok, st.penalty}, 3'b110);
    chk({design_active, limited_mode, penalty_req}, 3'b100);
  endtask

  task automatic t_detect();
    wr(TDM_OFF_EXT_HI, 32'h800, 4'hf);
    integrity_err    <= 1'b1;
    monitor_alarm    <= 4'h2;
    vref_internal    <= 1'b1;
    ext_sample       <= 12'h900;
    ext_sample_valid <= 1'b1;
    @(posedge aclk);
    integrity_err    <= 1'b0;
    ext_sample_valid <= 1'b0;
    i_tdm_tap_model.frame(8'hf0, 8'h3c);
    repeat (8) @(posedge aclk);
    rd(TDM_OFF_STATUS);
    chk(st.sticky, 9'h1bb);
    chk(st.vref_internal, 1);
    chk({penalty_req, design_active}, 2'b01);
  endtask

  task automatic t_penalty();
    wr(TDM_OFF_PEN_SEL, 32'h1, 4'hf);
    wr(TDM_OFF_CTRL, 32'h13, 4'hf);
    wr(TDM_OFF_STATUS, 32'h0, 4'hf);
    chk(resp, TDM_RESP_OKAY);
    wr(TDM_OFF_DET_EN, 32'h80, 4'hf);
    repeat (4) @(posedge aclk);
    chk({penalty_req, outputs_off, flops_restore, design_active}, 4'b1100);
    chk(fuse_burn_req, 1);
    rd(TDM_OFF_STATUS);
    chk({st.penalty, st.sticky}, 10'h3bb);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {integrity_err, vref_internal, ext_sample_valid} = '0;
    monitor_alarm = '0;
    ext_sample = '0;
    ident = {96'h0123_4567_89ab_cdef_fedc_ba98, 32'h5a5a_c3c3};
    repeat (5) @(posedge aclk);
    rst();
    t_reset_values();
    t_chain();
    t_id_bad();
    rst();
    t_id_good();
    t_detect();
    t_penalty();
    complete_run();
  end

  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
